// ### shared/cbsc_pkg.sv
// cbsc_pkg: offsets, field positions, reset values and states of the
// buffer status and control block.
// assumes a 16-bit register port with 8-bit word addresses.
package cbsc_pkg;

    // ====================
    // sizes
    localparam int CBSC_DATA_W     = 16;
    localparam int CBSC_ADDR_W     = 8;
    localparam int CBSC_NUM_RX_BUF = 32;
    localparam int CBSC_NUM_TX_BUF = 8;
    localparam int CBSC_OVF_BASE   = 16;
    localparam int CBSC_OVF_W      = 16;
    localparam int CBSC_PRI_W      = 2;
    localparam int CBSC_SID_W      = 11;
    localparam int CBSC_IRQ_W      = 6;

    // ====================
    // register word addresses
    localparam logic [7:0] CBSC_ADDR_FULL_LO = 8'h00;
    localparam logic [7:0] CBSC_ADDR_FULL_HI = 8'h01;
    localparam logic [7:0] CBSC_ADDR_OVF_HI  = 8'h02;
    localparam logic [7:0] CBSC_ADDR_TXC0    = 8'h04;
    localparam logic [7:0] CBSC_ADDR_TXC3    = 8'h07;
    localparam logic [7:0] CBSC_ADDR_SID0    = 8'h08;
    localparam logic [7:0] CBSC_ADDR_SID7    = 8'h0F;
    localparam logic [7:0] CBSC_ADDR_IRQ_ST  = 8'h10;
    localparam logic [7:0] CBSC_ADDR_IRQ_MSK = 8'h11;

    // ====================
    // tx control byte fields (one byte per buffer)
    localparam int CBSC_TXC_PRI_LSB = 0;
    localparam int CBSC_TXC_REQ     = 3;
    localparam int CBSC_TXC_ERR     = 4;
    localparam int CBSC_TXC_LARB    = 5;
    localparam int CBSC_TXC_ABT     = 6;

    // ====================
    // standard identifier word fields
    localparam int CBSC_SID_IDE_BIT = 0;
    localparam int CBSC_SID_SRR_BIT = 1;
    localparam int CBSC_SID_LSB     = 2;
    localparam int CBSC_SID_MSB     = 12;
    localparam logic [15:0] CBSC_SID_IMPL_MASK = 16'h1FFF;

    // ====================
    // interrupt status bits
    localparam int CBSC_IRQ_RX_STORED = 0;
    localparam int CBSC_IRQ_RX_OVF    = 1;
    localparam int CBSC_IRQ_TX_OK     = 2;
    localparam int CBSC_IRQ_TX_ABT    = 3;
    localparam int CBSC_IRQ_TX_LARB   = 4;
    localparam int CBSC_IRQ_TX_ERR    = 5;

    // ====================
    // reset values
    localparam logic [15:0] CBSC_RST_WORD = 16'h0000;
    localparam logic [1:0]  CBSC_RST_PRI  = 2'h0;

    // ====================
    // transmit scheduler states
    typedef enum logic [0:0] {
        CBSC_TX_IDLE = 1'b0,
        CBSC_TX_BUSY = 1'b1
    } cbsc_tx_state_t;

endpackage

// ### core/cbsc_sticky_flags.sv
// cbsc_sticky_flags: vector of flags set by hardware, cleared by
// software.
// assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module cbsc_sticky_flags #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // set and clear
    input  wire logic [W-1:0] set_vec,
    input  wire logic [W-1:0] clr_vec,
    // state
    output logic      [W-1:0] flags_reg
);

    // ====================
    // flags
    // set after clear: an event in the clearing cycle survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~clr_vec) | set_vec;
        end
    end

endmodule // cbsc_sticky_flags

// ### core/cbsc_tx_pick.sv
// cbsc_tx_pick: chooses the next pending transmit buffer.
// assumes flat priority vector, two bits per buffer, buffer 0 lowest.
`timescale 1ns/1ps
module cbsc_tx_pick
    import cbsc_pkg::*;
#(
    parameter int N   = CBSC_NUM_TX_BUF,
    parameter int IDX = $clog2(CBSC_NUM_TX_BUF)
) (
    // request side
    input  wire logic [N-1:0]            pending,
    input  wire logic [N*CBSC_PRI_W-1:0] pri_flat,
    // choice
    output logic                         any_pending,
    output logic [IDX-1:0]               sel_idx
);

    // ====================
    // selection
    // highest priority wins, ties go to the higher buffer number
    always_comb begin
        logic [CBSC_PRI_W-1:0] best;
        best        = '0;
        any_pending = 1'b0;
        sel_idx     = '0;
        for (int b = 0; b < N; b++) begin
            if (pending[b] &&
                (!any_pending ||
                 pri_flat[b*CBSC_PRI_W +: CBSC_PRI_W] >= best)) begin
                any_pending = 1'b1;
                best        = pri_flat[b*CBSC_PRI_W +: CBSC_PRI_W];
                sel_idx     = IDX'(b);
            end
        end
    end

endmodule // cbsc_tx_pick

// ### core/cbsc_buffer_ctrl.sv
// cbsc_buffer_ctrl: receive full/overflow flags, transmit request and
// result flags, identifier format and interrupt for CAN message buffers.
// assumes the protocol engine runs on clk and reports each receive
// store and each transmit end as a one-cycle pulse.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cbsc_buffer_ctrl
    import cbsc_pkg::*;
#(
    parameter int NUM_TX = CBSC_NUM_TX_BUF,
    parameter int TX_IDX = $clog2(CBSC_NUM_TX_BUF),
    parameter int RX_IDX = $clog2(CBSC_NUM_RX_BUF)
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // register port
    input  wire logic [CBSC_ADDR_W-1:0] addr,
    input  wire logic [CBSC_DATA_W-1:0] wr_data,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [CBSC_DATA_W-1:0] rd_data_reg,
    // receive store events from the engine
    input  wire logic                   rx_store,
    input  wire logic [RX_IDX-1:0]      rx_store_buf,
    // transmit hand-off to the engine
    input  wire logic                   tx_engine_ready,
    output logic                        tx_start_reg,
    output logic      [TX_IDX-1:0]      tx_buf_reg,
    output logic                        tx_ext_id_reg,
    output logic                        tx_rtr_sub_reg,
    output logic      [CBSC_SID_W-1:0]  tx_sid_reg,
    // transmit result from the engine
    input  wire logic                   tx_done,
    input  wire logic                   tx_done_aborted,
    input  wire logic                   tx_done_lost_arb,
    input  wire logic                   tx_done_bus_err,
    // interrupt
    output logic                        irq_reg
);

    // ====================
    // helpers
    function automatic logic [7:0] txc_byte(
        input logic                  abt,
        input logic                  larb,
        input logic                  err,
        input logic                  req,
        input logic [CBSC_PRI_W-1:0] pri
    );
        logic [7:0] v;
        v                                      = 8'h00;
        v[CBSC_TXC_ABT]                        = abt;
        v[CBSC_TXC_LARB]                       = larb;
        v[CBSC_TXC_ERR]                        = err;
        v[CBSC_TXC_REQ]                        = req;
        v[CBSC_TXC_PRI_LSB +: CBSC_PRI_W]      = pri;
        return v;
    endfunction

    function automatic logic in_range(
        input logic [CBSC_ADDR_W-1:0] a,
        input logic [CBSC_ADDR_W-1:0] lo,
        input logic [CBSC_ADDR_W-1:0] hi
    );
        return (a >= lo) && (a <= hi);
    endfunction

    // ====================
    // declarations
    logic [CBSC_NUM_RX_BUF-1:0] full_flags;
    logic [CBSC_NUM_RX_BUF-1:0] full_set;
    logic [CBSC_NUM_RX_BUF-1:0] full_clr;
    logic [CBSC_OVF_W-1:0]      ovf_flags;
    logic [CBSC_OVF_W-1:0]      ovf_set;
    logic [CBSC_OVF_W-1:0]      ovf_clr;
    logic [CBSC_IRQ_W-1:0]      irq_flags;
    logic [CBSC_IRQ_W-1:0]      irq_set;
    logic [CBSC_IRQ_W-1:0]      irq_clr;
    logic [CBSC_IRQ_W-1:0]      irq_mask_reg;

    logic [NUM_TX-1:0]          req_reg;
    logic [NUM_TX-1:0]          abt_reg;
    logic [NUM_TX-1:0]          larb_reg;
    logic [NUM_TX-1:0]          err_reg;
    logic [CBSC_PRI_W-1:0]      pri_reg [NUM_TX];
    logic [CBSC_DATA_W-1:0]     sid_reg [NUM_TX];
    logic [NUM_TX*CBSC_PRI_W-1:0] pri_flat;

    cbsc_tx_state_t             tx_state_reg;
    logic                       pick_any;
    logic [TX_IDX-1:0]          pick_idx;
    logic                       tx_end;
    logic                       rx_hit_full;
    logic                       rx_high;
    logic [CBSC_DATA_W-1:0]     rd_next;

    logic                       wr_txc;
    logic                       wr_sid;
    logic [1:0]                 txc_pair;
    logic [TX_IDX-1:0]          sid_idx;

    // ====================
    // write decode
    assign wr_txc   = wr_en && in_range(addr, CBSC_ADDR_TXC0,
                                              CBSC_ADDR_TXC3);
    assign wr_sid   = wr_en && in_range(addr, CBSC_ADDR_SID0,
                                              CBSC_ADDR_SID7);
    assign txc_pair = 2'(addr - CBSC_ADDR_TXC0);
    assign sid_idx  = TX_IDX'(addr - CBSC_ADDR_SID0);

    // ====================
    // receive full and overflow flags
    assign rx_hit_full = full_flags[rx_store_buf];
    assign rx_high     = rx_store_buf >= RX_IDX'(CBSC_OVF_BASE);

    always_comb begin
        full_set = '0;
        ovf_set  = '0;
        if (rx_store && !rx_hit_full) begin
            full_set[rx_store_buf] = 1'b1;
        end
        if (rx_store && rx_hit_full && rx_high) begin
            // overflow kept only for the upper half of the buffers
            ovf_set[4'(rx_store_buf - RX_IDX'(CBSC_OVF_BASE))] = 1'b1;
        end
    end

    // clear-by-zero: writing one leaves a flag untouched
    always_comb begin
        full_clr = '0;
        ovf_clr  = '0;
        if (wr_en && addr == CBSC_ADDR_FULL_LO) begin
            full_clr[15:0] = ~wr_data;
        end
        if (wr_en && addr == CBSC_ADDR_FULL_HI) begin
            full_clr[31:16] = ~wr_data;
        end
        if (wr_en && addr == CBSC_ADDR_OVF_HI) begin
            ovf_clr = ~wr_data;
        end
    end

    cbsc_sticky_flags #(
        .W         (CBSC_NUM_RX_BUF)
    ) u_full (
        .clk       (clk),
        .rst       (rst),
        .set_vec   (full_set),
        .clr_vec   (full_clr),
        .flags_reg (full_flags)
    );

    cbsc_sticky_flags #(
        .W         (CBSC_OVF_W)
    ) u_ovf (
        .clk       (clk),
        .rst       (rst),
        .set_vec   (ovf_set),
        .clr_vec   (ovf_clr),
        .flags_reg (ovf_flags)
    );

    // ====================
    // transmit request bits
    assign tx_end = (tx_state_reg == CBSC_TX_BUSY) && tx_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_reg <= '0;
        end else begin
            for (int b = 0; b < NUM_TX; b++) begin
                if (tx_end && tx_buf_reg == TX_IDX'(b)) begin
                    req_reg[b] <= 1'b0;
                end
                // a fresh request in the ending cycle is kept
                if (wr_txc && txc_pair == 2'(b / 2) &&
                    wr_data[(b % 2) * 8 + CBSC_TXC_REQ]) begin
                    req_reg[b] <= 1'b1;
                end
            end
        end
    end

    // ====================
    // transmit result flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            abt_reg  <= '0;
            larb_reg <= '0;
            err_reg  <= '0;
        end else if (tx_end) begin
            abt_reg[tx_buf_reg]  <= tx_done_aborted;
            larb_reg[tx_buf_reg] <= tx_done_lost_arb;
            err_reg[tx_buf_reg]  <= tx_done_bus_err;
        end
    end

    // ====================
    // priority and identifier words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < NUM_TX; b++) begin
                pri_reg[b] <= CBSC_RST_PRI;
            end
        end else if (wr_txc) begin
            for (int b = 0; b < NUM_TX; b++) begin
                if (txc_pair == 2'(b / 2)) begin
                    pri_reg[b] <= wr_data[(b % 2) * 8 + CBSC_TXC_PRI_LSB
                                          +: CBSC_PRI_W];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < NUM_TX; b++) begin
                sid_reg[b] <= CBSC_RST_WORD;
            end
        end else if (wr_sid) begin
            // unimplemented upper bits never stored, so they read zero
            sid_reg[sid_idx] <= wr_data & CBSC_SID_IMPL_MASK;
        end
    end

    // ====================
    // transmit scheduling
    always_comb begin
        for (int b = 0; b < NUM_TX; b++) begin
            pri_flat[b*CBSC_PRI_W +: CBSC_PRI_W] = pri_reg[b];
        end
    end

    cbsc_tx_pick #(
        .N           (NUM_TX),
        .IDX         (TX_IDX)
    ) u_pick (
        .pending     (req_reg),
        .pri_flat    (pri_flat),
        .any_pending (pick_any),
        .sel_idx     (pick_idx)
    );

    // one message in flight; its request stays set until it ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_reg <= CBSC_TX_IDLE;
        end else begin
            case (tx_state_reg)
                CBSC_TX_IDLE: begin
                    if (tx_engine_ready && pick_any) begin
                        tx_state_reg <= CBSC_TX_BUSY;
                    end
                end
                CBSC_TX_BUSY: begin
                    if (tx_done) begin
                        tx_state_reg <= CBSC_TX_IDLE;
                    end
                end
                default: begin
                    tx_state_reg <= CBSC_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_start_reg   <= 1'b0;
            tx_buf_reg     <= '0;
            tx_ext_id_reg  <= 1'b0;
            tx_rtr_sub_reg <= 1'b0;
            tx_sid_reg     <= '0;
        end else begin
            tx_start_reg <= 1'b0;
            if (tx_state_reg == CBSC_TX_IDLE && tx_engine_ready &&
                pick_any) begin
                tx_start_reg   <= 1'b1;
                tx_buf_reg     <= pick_idx;
                tx_ext_id_reg  <= sid_reg[pick_idx][CBSC_SID_IDE_BIT];
                tx_rtr_sub_reg <= sid_reg[pick_idx][CBSC_SID_SRR_BIT];
                tx_sid_reg     <= sid_reg[pick_idx][CBSC_SID_MSB:
                                                    CBSC_SID_LSB];
            end
        end
    end

    // ====================
    // interrupt
    always_comb begin
        irq_set                     = '0;
        irq_set[CBSC_IRQ_RX_STORED] = |full_set;
        irq_set[CBSC_IRQ_RX_OVF]    = rx_store && rx_hit_full;
        irq_set[CBSC_IRQ_TX_OK]     = tx_end && !tx_done_aborted &&
                                      !tx_done_bus_err;
        irq_set[CBSC_IRQ_TX_ABT]    = tx_end && tx_done_aborted;
        irq_set[CBSC_IRQ_TX_LARB]   = tx_end && tx_done_lost_arb;
        irq_set[CBSC_IRQ_TX_ERR]    = tx_end && tx_done_bus_err;
    end

    assign irq_clr = (wr_en && addr == CBSC_ADDR_IRQ_ST) ?
                     wr_data[CBSC_IRQ_W-1:0] : '0;

    cbsc_sticky_flags #(
        .W         (CBSC_IRQ_W)
    ) u_irq (
        .clk       (clk),
        .rst       (rst),
        .set_vec   (irq_set),
        .clr_vec   (irq_clr),
        .flags_reg (irq_flags)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else if (wr_en && addr == CBSC_ADDR_IRQ_MSK) begin
            irq_mask_reg <= wr_data[CBSC_IRQ_W-1:0];
        end
    end

    // registered, so the line lags the status flags by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_flags & irq_mask_reg);
        end
    end

    // ====================
    // read path
    always_comb begin
        rd_next = '0;
        if (in_range(addr, CBSC_ADDR_TXC0, CBSC_ADDR_TXC3)) begin
            for (int b = 0; b < NUM_TX; b++) begin
                if (txc_pair == 2'(b / 2)) begin
                    rd_next[(b % 2) * 8 +: 8] =
                        txc_byte(abt_reg[b], larb_reg[b], err_reg[b],
                                 req_reg[b], pri_reg[b]);
                end
            end
        end else if (in_range(addr, CBSC_ADDR_SID0, CBSC_ADDR_SID7)) begin
            rd_next = sid_reg[sid_idx];
        end else begin
            case (addr)
                CBSC_ADDR_FULL_LO: rd_next = full_flags[15:0];
                CBSC_ADDR_FULL_HI: rd_next = full_flags[31:16];
                CBSC_ADDR_OVF_HI:  rd_next = ovf_flags;
                CBSC_ADDR_IRQ_ST:  rd_next = 16'(irq_flags);
                CBSC_ADDR_IRQ_MSK: rd_next = 16'(irq_mask_reg);
                default:           rd_next = '0;
            endcase
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= CBSC_RST_WORD;
        end else if (rd_en) begin
            rd_data_reg <= rd_next;
        end else begin
            rd_data_reg <= CBSC_RST_WORD;
        end
    end

endmodule // cbsc_buffer_ctrl

// ### test/cbsc_engine_model.sv
// cbsc_engine_model: protocol engine stand-in, one result per attempt.
// assumes result code and latency are set by the bench before a start.
`timescale 1ns/1ps
module cbsc_engine_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // start from the block, result setup from the bench
    input  wire logic       tx_start,
    input  wire logic [2:0] res,
    input  wire logic [3:0] lat,
    // hand-off and result
    output logic            ready,
    output logic            done,
    output logic            abt,
    output logic            larb,
    output logic            err
);
    // ====================
    // attempt timing
    logic [3:0] cnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b1;
            done <= 1'b0;
            cnt_reg <= 4'h0;
            {abt, larb, err} <= 3'h5;
        end else begin
            done <= 1'b0;
            // toggled outside done so a stale result never looks valid
            {abt, larb, err} <= ~{abt, larb, err};
            if (tx_start) begin
                ready <= 1'b0;
                cnt_reg <= lat;
            end else if (!ready && cnt_reg == 4'h0) begin
                ready <= 1'b1;
                done <= 1'b1;
                {abt, larb, err} <= res;
            end else if (!ready) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule // cbsc_engine_model

// ### test/cbsc_buffer_ctrl_asserts.sv
// cbsc_buffer_ctrl_asserts: port checks of the buffer control block.
// assumes it is bound onto cbsc_buffer_ctrl; one clock domain.
`timescale 1ns/1ps
module cbsc_buffer_ctrl_asserts
    import cbsc_pkg::*;
#(
    parameter int TX_IDX = $clog2(CBSC_NUM_TX_BUF)
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // register port
    input wire logic [CBSC_ADDR_W-1:0] addr,
    input wire logic                   wr_en,
    input wire logic                   rd_en,
    input wire logic [CBSC_DATA_W-1:0] rd_data_reg,
    // engine side and interrupt
    input wire logic                   rx_store,
    input wire logic                   tx_engine_ready,
    input wire logic                   tx_start_reg,
    input wire logic [TX_IDX-1:0]      tx_buf_reg,
    input wire logic                   tx_ext_id_reg,
    input wire logic [CBSC_SID_W-1:0]  tx_sid_reg,
    input wire logic                   tx_done,
    input wire logic                   irq_reg
);
    // ====================
    // attempt tracker: high from start until the engine ends it
    logic busy_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (tx_start_reg) begin
            busy_reg <= 1'b1;
        end else if (tx_done) begin
            busy_reg <= 1'b0;
        end
    end
    // ====================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_read_idle_zero: assert property (
        !$past(rd_en) |-> rd_data_reg == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (
        $past(rd_en) && $past(addr) > CBSC_ADDR_IRQ_MSK |->
        rd_data_reg == 16'h0000) else $error("unmapped read not zero");
    a_sid_top_zero: assert property (
        $past(rd_en) && $past(addr) >= CBSC_ADDR_SID0 &&
        $past(addr) <= CBSC_ADDR_SID7 |-> rd_data_reg[15:13] == 3'h0)
        else $error("identifier word top bits not zero");
    a_start_pulse: assert property (tx_start_reg |=> !tx_start_reg)
        else $error("start longer than one cycle");
    a_start_ready: assert property (
        tx_start_reg |-> $past(tx_engine_ready))
        else $error("start while engine not ready");
    a_start_idle: assert property (tx_start_reg |-> !busy_reg)
        else $error("start before previous attempt ended");
    a_ids_hold: assert property (!tx_start_reg |-> $stable(tx_buf_reg) &&
        $stable(tx_ext_id_reg) && $stable(tx_sid_reg))
        else $error("message fields changed without a start");
    a_irq_cause: assert property ($rose(irq_reg) |-> $past(tx_done, 2) ||
        $past(rx_store, 2) || $past(wr_en, 2))
        else $error("interrupt rose without a cause");
endmodule // cbsc_buffer_ctrl_asserts
bind cbsc_buffer_ctrl cbsc_buffer_ctrl_asserts #(.TX_IDX(TX_IDX)) u_chk (
    .clk, .rst, .addr, .wr_en, .rd_en, .rd_data_reg, .rx_store,
    .tx_engine_ready, .tx_start_reg, .tx_buf_reg, .tx_ext_id_reg,
    .tx_sid_reg, .tx_done, .irq_reg);

// ### test/cbsc_buffer_ctrl_tb_top.sv
// cbsc_buffer_ctrl_tb_top: self-checking bench for the buffer block.
// assumes the engine model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, g, e); end end
module cbsc_buffer_ctrl_tb_top
    import cbsc_pkg::*;
;
    typedef struct {
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } cbsc_row_t;
    // ====================
    // signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_data_reg, got;
    logic        wr_en = 1'b0, rd_en = 1'b0, rx_store = 1'b0;
    logic [4:0]  rx_store_buf = 5'h00;
    logic [2:0]  res = 3'h0, tx_buf_reg;
    logic [3:0]  lat = 4'h0;
    logic [10:0] tx_sid_reg;
    logic        tx_engine_ready, tx_start_reg, tx_ext_id_reg;
    logic        tx_rtr_sub_reg, tx_done, irq_reg;
    logic        tx_done_aborted, tx_done_lost_arb, tx_done_bus_err;
    int          miscompares = 0, comparisons = 0, cyc = 0;
    // result codes {abort, lost arb, bus err} and the status they raise
    logic [2:0]  codes [4] = '{3'h0, 3'h4, 3'h6, 3'h1};
    logic [15:0] irqs [4] = '{16'h0004, 16'h0008, 16'h0018, 16'h0020};
    cbsc_row_t   rows [9] = '{'{8'h08, 16'hFFFF, 16'h1FFF},
        '{8'h0F, 16'h1235, 16'h1235}, '{8'h04, 16'h7373, 16'h0303},
        '{8'h07, 16'h0202, 16'h0202}, '{8'h11, 16'h003F, 16'h003F},
        '{8'h00, 16'hFFFF, 16'h0000}, '{8'h02, 16'hFFFF, 16'h0000},
        '{8'h03, 16'hFFFF, 16'h0000}, '{8'hFF, 16'hFFFF, 16'h0000}};
    always #2 clk = ~clk;
    cbsc_buffer_ctrl dut (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data_reg, .rx_store, .rx_store_buf, .tx_engine_ready,
        .tx_start_reg, .tx_buf_reg, .tx_ext_id_reg, .tx_rtr_sub_reg,
        .tx_sid_reg, .tx_done, .tx_done_aborted, .tx_done_lost_arb,
        .tx_done_bus_err, .irq_reg);
    cbsc_engine_model u_eng (.clk, .rst, .tx_start(tx_start_reg), .res,
        .lat, .ready(tx_engine_ready), .done(tx_done),
        .abt(tx_done_aborted), .larb(tx_done_lost_arb),
        .err(tx_done_bus_err));
    // ====================
    // tasks
    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data_reg;
        @(posedge clk);
    endtask
    task automatic rx(input logic [4:0] b);
        rx_store_buf <= b;
        rx_store <= 1'b1;
        @(posedge clk);
        rx_store <= 1'b0;
        @(posedge clk);
    endtask
    // bounded wait for a start (0) or an attempt end (1)
    task automatic wait_hi(input bit sel);
        int n = 0;
        #1;
        while ((sel ? tx_done : tx_start_reg) !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("counts: %0d compared, %0d failed", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    // ====================
    // sequence
    initial begin
        reset_dut();
        for (int k = 0; k < 9; k++) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, got);
            `CHK(got, rows[k].e)
        end
        $display("done: register table");
        reset_dut();
        for (int k = 0; k < 18; k++) begin
            rd(8'(k), got);
            `CHK(got, 16'h0000)
        end
        $display("done: reset values");
        rx(5'd20);
        rd(CBSC_ADDR_FULL_HI, got);
        `CHK(got, 16'h0010)
        rx(5'd20);
        rx(5'd3);
        rx(5'd3);
        rd(CBSC_ADDR_FULL_LO, got);
        `CHK(got, 16'h0008)
        rd(CBSC_ADDR_OVF_HI, got);
        `CHK(got, 16'h0010)
        `CHK(irq_reg, 1'b0)
        wr(CBSC_ADDR_IRQ_MSK, 16'h0003);
        @(posedge clk);
        #1;
        `CHK(irq_reg, 1'b1)
        rd(CBSC_ADDR_IRQ_ST, got);
        `CHK(got, 16'h0003)
        wr(CBSC_ADDR_OVF_HI, 16'hFFEF);
        wr(CBSC_ADDR_FULL_HI, 16'hFFEF);
        wr(CBSC_ADDR_FULL_LO, 16'hFFF7);
        wr(CBSC_ADDR_IRQ_ST, 16'h0003);
        for (int k = 0; k < 3; k++) begin
            rd(8'(k), got);
            `CHK(got, 16'h0000)
        end
        `CHK(irq_reg, 1'b0)
        $display("done: receive flags");
        for (int i = 0; i < 4; i++) begin
            res <= codes[i];
            lat <= 4'(3 * i);
            wr(CBSC_ADDR_SID0 + 8'(2 * i), 16'((i << 2) | i));
            wr(CBSC_ADDR_TXC0 + 8'(i), 16'h0008);
            wait_hi(1'b0);
            `CHK(tx_buf_reg, 3'(2 * i))
            `CHK(tx_ext_id_reg, 1'(i & 1))
            `CHK(tx_rtr_sub_reg, 1'(i >> 1))
            `CHK(tx_sid_reg, 11'(i))
            wait_hi(1'b1);
            @(posedge clk);
            rd(CBSC_ADDR_TXC0 + 8'(i), got);
            `CHK(got, {9'h000, codes[i], 4'h0})
            rd(CBSC_ADDR_IRQ_ST, got);
            `CHK(got, irqs[i])
            wr(CBSC_ADDR_IRQ_ST, 16'h003F);
        end
        $display("done: transmit results");
        res <= 3'h0;
        lat <= 4'h2;
        wr(CBSC_ADDR_TXC3, 16'h0808);
        wait_hi(1'b0);
        `CHK(tx_buf_reg, 3'h7)
        wait_hi(1'b1);
        wait_hi(1'b0);
        `CHK(tx_buf_reg, 3'h6)
        wait_hi(1'b1);
        lat <= 4'hF;
        wr(8'h05, 16'h0809);
        wait_hi(1'b0);
        `CHK(tx_buf_reg, 3'h2)
        wr(8'h05, 16'h0000);
        rd(8'h05, got);
        `CHK(got, 16'h0848)
        wait_hi(1'b1);
        wait_hi(1'b0);
        `CHK(tx_buf_reg, 3'h3)
        wait_hi(1'b1);
        $display("done: scheduling");
        wrap_up();
    end
endmodule // cbsc_buffer_ctrl_tb_top
